// *** rtl/ctl_instr_exec.sv ***
// execution unit for no-op, returns and configuration load
`timescale 1ns/10ps
`default_nettype none
module return_and_config_instr_exec
   import ctl_instr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [WORD_W-1:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic call_i,
   input wire logic [PC_W-1:0] call_target_i,
   input wire logic dm_we_i,
   input wire logic [DATA_W-1:0] dm_addr_i,
   input wire logic [DATA_W-1:0] dm_wdata_i,
   input wire logic intctl_we_i,
   input wire logic [DATA_W-1:0] intctl_wdata_i,
   input wire logic w_we_i,
   input wire logic [DATA_W-1:0] w_wdata_i,
   output logic [PC_W-1:0] pc_o,
   output logic [DATA_W-1:0] w_o,
   output logic [DATA_W-1:0] cfg_o,
   output logic [DATA_W-1:0] intctl_o,
   output logic [DATA_W-1:0] dm_rdata_o,
   output logic flush_o,
   output logic busy_o
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic op_match(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] op,
                                     input logic [WORD_W-1:0] m);
      op_match = ((w & m) == op);
   endfunction : op_match

   exec_state_t state;
   exec_state_t next_state;
   logic run;
   logic is_nop;
   logic is_retint;
   logic is_retlit;
   logic is_cfg;
   logic is_ret;
   logic [PC_W-1:0] tos;

   assign run = ce_i && instr_valid_i && (state == ST_EXEC);
   // a call shares the all-zero word, so it must not count as a no-op
   assign is_nop = run && !call_i && op_match(instr_i, OP_NOP, MASK_NOP);
   assign is_retint = run && op_match(instr_i, OP_RETINT, MASK_FULL);
   assign is_cfg = run && op_match(instr_i, OP_CFGLOAD, MASK_FULL);
   assign is_retlit = run && op_match(instr_i, OP_RETLIT, MASK_RETLIT);
   assign is_ret = is_retint || is_retlit;

   // ------------------------------------------------------------
   // stack
   // ------------------------------------------------------------
   // pop on return
   ret_stack u_stack (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .push_i(call_i && run),
      .pop_i(is_ret),
      .push_data_i(pc_o + PC_ONE),
      .tos_o(tos)
   );

   // ------------------------------------------------------------
   // sequencing: a return spends a second cycle flushing the fetch
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_EXEC: begin
            if (is_ret) begin
               next_state = ST_FLUSH;
            end
         end
         ST_FLUSH: begin
            next_state = ST_EXEC;
         end
         default: begin
            next_state = ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state <= ST_EXEC;
         flush_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         flush_o <= is_ret;
         busy_o <= is_ret;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pc_o <= PC_RESET;
      end else if (ce_i) begin
         if (is_ret) begin
            pc_o <= tos;
         end else if (call_i && run) begin
            pc_o <= call_target_i;
         end else if (run) begin
            pc_o <= pc_o + PC_ONE;
         end
      end
   end

   // ------------------------------------------------------------
   // working register
   // ------------------------------------------------------------
   // literal into w
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         w_o <= W_RESET;
      end else if (ce_i) begin
         if (is_retlit) begin
            w_o <= instr_i[LIT_LSB +: DATA_W];
         end else if (w_we_i && !is_nop) begin
            w_o <= w_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt control register
   // ------------------------------------------------------------
   // set global enable, hardware set wins
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         intctl_o <= INTCTL_RESET;
      end else if (ce_i) begin
         if (intctl_we_i) begin
            intctl_o <= intctl_wdata_i;
         end
         if (is_retint) begin
            intctl_o[INT_ENABLE_BIT] <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   // w copied in one cycle
   // direct data-memory write
   // firmware is expected to use the direct path, the opcode stays for old code
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cfg_o <= CFG_RESET;
      end else if (ce_i) begin
         if (is_cfg) begin
            cfg_o <= w_o;
         end else if (dm_we_i && dm_addr_i == CFG_ADDR) begin
            cfg_o <= dm_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         dm_rdata_o <= '0;
      end else if (ce_i) begin
         dm_rdata_o <= (dm_addr_i == CFG_ADDR) ? cfg_o : '0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_ret_taken;
      ce_i && is_ret;
   endsequence

   sequence s_flush_cycle;
      ce_i && (state == ST_FLUSH);
   endsequence

   a_retint_pc: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && is_retint) |=> pc_o == $past(tos))
      else $error("interrupt return did not load pc");
   a_retint_gie: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && is_retint) |=> intctl_o[INT_ENABLE_BIT])
      else $error("global interrupt enable not set");
   a_retlit_w: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && is_retlit) |=> w_o == $past(instr_i[LIT_LSB +: DATA_W]))
      else $error("literal not loaded into w");
   a_retlit_pc: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && is_retlit) |=> pc_o == $past(tos))
      else $error("literal return did not load pc");
   a_ret_flush: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      s_ret_taken |=> (state == ST_FLUSH) && flush_o)
      else $error("return not two cycles");
   a_flush_drop: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      s_flush_cycle |=> $stable(pc_o) && !flush_o)
      else $error("instruction taken in flush cycle");
   a_cfg_load: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && is_cfg) |=> cfg_o == $past(w_o))
      else $error("configuration load failed");
   a_cfg_read: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && dm_addr_i == CFG_ADDR) |=> dm_rdata_o == $past(cfg_o))
      else $error("configuration read mismatch");
   // no-op keeps w and advances pc
   a_nop_quiet: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && is_nop) |=> (w_o == $past(w_o)) && (pc_o == $past(pc_o) + PC_ONE))
      else $error("no-op changed state");
   // enable low freezes state
   a_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !ce_i |=> $stable(pc_o) && $stable(cfg_o) && $stable(w_o) && $stable(intctl_o))
      else $error("state moved with enable low");
endmodule : return_and_config_instr_exec
`default_nettype wire

// *** rtl/ctl_instr_pkg.sv ***
// constants shared by the control-instruction execution unit
package ctl_instr_pkg;
   localparam int unsigned WORD_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PC_W = 13;
   localparam int unsigned STACK_DEPTH = 8;
   localparam int unsigned SP_W = 3;
   // opcodes and masks
   localparam logic [13:0] OP_NOP = 14'h0000;
   localparam logic [13:0] MASK_NOP = 14'h3F9F;
   localparam logic [13:0] OP_RETINT = 14'h0009;
   localparam logic [13:0] OP_CFGLOAD = 14'h0062;
   localparam logic [13:0] MASK_FULL = 14'h3FFF;
   localparam logic [13:0] OP_RETLIT = 14'h3400;
   localparam logic [13:0] MASK_RETLIT = 14'h3C00;
   // field positions
   localparam int unsigned LIT_LSB = 0;
   localparam int unsigned INT_ENABLE_BIT = 7;
   // data-memory address of the configuration register
   localparam logic [7:0] CFG_ADDR = 8'h81;
   // reset values
   localparam logic [7:0] CFG_RESET = 8'hFF;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_ONE = 13'h0001;
   localparam logic [2:0] SP_ONE = 3'h1;
   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_FLUSH = 2'b01
   } exec_state_t;
endpackage : ctl_instr_pkg

// *** rtl/ret_stack.sv ***
// hardware return-address stack, circular, eight entries
`timescale 1ns/10ps
`default_nettype none
module ret_stack
   import ctl_instr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [PC_W-1:0] push_data_i,
   output logic [PC_W-1:0] tos_o
);
   logic [PC_W-1:0] mem [STACK_DEPTH];
   logic [SP_W-1:0] sp;

   // overflow wraps silently, as the core has no stack-full flag
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sp <= '0;
      end else if (ce_i) begin
         if (push_i) begin
            sp <= sp + SP_ONE;
         end else if (pop_i) begin
            sp <= sp - SP_ONE;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (ce_i && push_i) begin
         mem[sp] <= push_data_i;
      end
   end

   assign tos_o = mem[sp - SP_ONE];
endmodule : ret_stack
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the control-instruction execution unit
`timescale 1ns/10ps
`default_nettype none
module testbench
   import ctl_instr_pkg::*;
;
   typedef struct {
      logic v; logic [13:0] ins; logic c; logic [12:0] tg; logic we; logic [7:0] wd;
      logic [12:0] pc; logic [7:0] w; logic [7:0] cfg; logic [7:0] ic; logic fl;
   } row_t;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, instr_valid = 1'b0, call = 1'b0, dm_we = 1'b0;
   logic ic_we = 1'b0, w_we = 1'b0, flush, busy;
   logic [13:0] instr = 14'h0000;
   logic [12:0] call_target = 13'h0000, pc;
   logic [7:0] dm_addr = 8'h00, dm_wdata = 8'h00, ic_wdata = 8'h00, w_wdata = 8'h00;
   logic [7:0] w, cfg, ic, rdata;
   int fail_count = 0, checked = 0, cyc = 0;
   row_t rows [9];

   return_and_config_instr_exec u_return_and_config_instr_exec (
      .clk_sys_i(clk), .srst_i(srst), .ce_i(ce), .instr_i(instr), .instr_valid_i(instr_valid),
      .call_i(call), .call_target_i(call_target), .dm_we_i(dm_we), .dm_addr_i(dm_addr),
      .dm_wdata_i(dm_wdata), .intctl_we_i(ic_we), .intctl_wdata_i(ic_wdata), .w_we_i(w_we),
      .w_wdata_i(w_wdata), .pc_o(pc), .w_o(w), .cfg_o(cfg), .intctl_o(ic), .dm_rdata_o(rdata),
      .flush_o(flush), .busy_o(busy));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // one request cycle, then one quiet cycle so a return's flush never swallows the next row
   task automatic step(input row_t r);
      @(posedge clk);
      instr_valid <= r.v;
      instr <= r.ins;
      call <= r.c;
      call_target <= r.tg;
      w_we <= r.we;
      w_wdata <= r.wd;
      @(posedge clk);
      instr_valid <= 1'b0;
      call <= 1'b0;
      w_we <= 1'b0;
      #1;
   endtask : step

   // hang guard, the whole run needs well under a hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      rows = '{
         '{1, 14'h0000, 1, 13'h0100, 0, 8'h00, 13'h0100, 8'h00, 8'hFF, 8'h00, 0},
         '{1, 14'h0000, 1, 13'h0200, 0, 8'h00, 13'h0200, 8'h00, 8'hFF, 8'h00, 0},
         '{0, 14'h0000, 0, 13'h0000, 1, 8'hA5, 13'h0200, 8'hA5, 8'hFF, 8'h00, 0},
         '{1, 14'h0062, 0, 13'h0000, 0, 8'h00, 13'h0201, 8'hA5, 8'hA5, 8'h00, 0},
         '{1, 14'h0060, 0, 13'h0000, 1, 8'h33, 13'h0202, 8'hA5, 8'hA5, 8'h00, 0},
         '{1, 14'h37C3, 0, 13'h0000, 0, 8'h00, 13'h0101, 8'hC3, 8'hA5, 8'h00, 1},
         '{1, 14'h0009, 0, 13'h0000, 0, 8'h00, 13'h0001, 8'hC3, 8'hA5, 8'h80, 1},
         '{1, 14'h0000, 1, 13'h0300, 0, 8'h00, 13'h0300, 8'hC3, 8'hA5, 8'h80, 0},
         '{1, 14'h34FF, 0, 13'h0000, 0, 8'h00, 13'h0002, 8'hFF, 8'hA5, 8'h80, 1}};
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      check("pc", pc, 16'h0000);
      check("cfg", cfg, 16'h00FF);
      $display("reset test done");
      foreach (rows[i]) begin
         step(rows[i]);
         check("pc", pc, rows[i].pc);
         check("w", w, rows[i].w);
         check("cfg", cfg, rows[i].cfg);
         check("intctl", ic, rows[i].ic);
         check("flush", flush, rows[i].fl);
         check("busy", busy, rows[i].fl);
      end
      $display("row test done");
      // request held straight into the flush cycle must be dropped
      step('{1, 14'h0000, 1, 13'h0050, 0, 8'h00, 13'h0, 8'h0, 8'h0, 8'h0, 0});
      @(posedge clk);
      instr <= 14'h3411;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr <= 14'h0000;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      check("pc", pc, 16'h0003);
      check("flush", flush, 16'h0000);
      check("w", w, 16'h0011);
      $display("flush test done");
      // software writes the enable low in the return's own cycle, the hardware set must win
      @(posedge clk);
      ic_we <= 1'b1;
      ic_wdata <= 8'h05;
      step('{1, 14'h0000, 1, 13'h0070, 0, 8'h00, 13'h0, 8'h0, 8'h0, 8'h0, 0});
      step('{1, 14'h0009, 0, 13'h0000, 0, 8'h00, 13'h0, 8'h0, 8'h0, 8'h0, 0});
      check("pc", pc, 16'h0004);
      check("intctl", ic, 16'h0085);
      check("busy", busy, 16'h0001);
      $display("interrupt return test done");
      @(posedge clk);
      ic_we <= 1'b0;
      @(posedge clk);
      dm_we <= 1'b1;
      dm_addr <= 8'h81;
      dm_wdata <= 8'h3C;
      @(posedge clk);
      dm_we <= 1'b0;
      @(posedge clk);
      dm_addr <= 8'h10;
      #1;
      check("cfg", cfg, 16'h003C);
      check("rdata", rdata, 16'h003C);
      @(posedge clk);
      #1;
      check("rdata", rdata, 16'h0000);
      $display("data memory test done");
      @(posedge clk);
      ce <= 1'b0;
      step('{1, 14'h0000, 0, 13'h0000, 0, 8'h00, 13'h0, 8'h0, 8'h0, 8'h0, 0});
      check("pc", pc, 16'h0004);
      check("cfg", cfg, 16'h003C);
      @(posedge clk);
      ce <= 1'b1;
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      #1;
      check("pc", pc, 16'h0000);
      check("intctl", ic, 16'h0000);
      check("w", w, 16'h0000);
      check("cfg", cfg, 16'h00FF);
      check("flush", flush, 16'h0000);
      check("busy", busy, 16'h0000);
      check("rdata", rdata, 16'h0000);
      $display("enable and reset test done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
